// ==== hdl/lis_pwm_unit.sv ====
`timescale 1ns/1ns
module lis_pwm_unit
  import lis_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     restart,
  input  wire logic                     state_step,
  input  wire logic                     mono,
  input  wire logic                     first_state,
  input  wire logic [lis_pkg::DIV_W-1:0] divider,
  input  wire logic [lis_pkg::PER_W-1:0] period,
  input  wire logic [lis_pkg::PER_W-1:0] on_count,
  input  wire logic [lis_pkg::EN_W-1:0]  en_first,
  input  wire logic [lis_pkg::EN_W-1:0]  en_last,
  output logic                          gate_en,
  output logic                          level,
  output logic                          period_done
);

  logic [DIV_W-1:0] div_cnt_reg;
  logic [PER_W-1:0] per_cnt_reg;
  logic [EN_W-1:0]  en_cnt_reg;
  logic             gate_reg;
  logic             level_reg;

  // ==========================================================
  // Decode
  wire             tick      = (div_cnt_reg == divider);
  wire             wrap      = tick && (per_cnt_reg == period);
  wire [EN_W-1:0]  en_inc    = en_cnt_reg + 8'h01;
  wire             en_full   = (en_cnt_reg == en_last);
  // Later mono states open at once: blanking is off after the first mono state
  wire [EN_W-1:0]  start_eff = (mono && !first_state) ? 8'h00 : en_first;
  wire             gate_next = (en_cnt_reg >= start_eff) && !en_full;

  assign period_done = wrap && !en_full && (en_inc == en_last);
  assign gate_en     = gate_reg;
  assign level       = level_reg;

  // ==========================================================
  // Counters
  // divided clock drives period counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= '0;
      per_cnt_reg <= '0;
    end else if (restart) begin
      div_cnt_reg <= '0;
      per_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= tick ? '0 : div_cnt_reg + 4'h1;
      if (tick) begin
        per_cnt_reg <= wrap ? '0 : per_cnt_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_cnt_reg <= '0;
    end else if (restart || state_step) begin
      en_cnt_reg <= '0;
    end else if (wrap && !en_full) begin
      en_cnt_reg <= en_inc;
    end
  end

  // start value in every colour state, but only in the first mono state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      gate_reg  <= gate_next;
      level_reg <= (per_cnt_reg < on_count);
    end
  end

  // ==========================================================
  // Checks
  a_period_wrap: assert property (
    @(posedge clk) disable iff (!rstn)
    (wrap && !restart) |=> (per_cnt_reg == '0))
    else $error("period counter did not wrap to zero");

  a_gate_stop: assert property (
    @(posedge clk) disable iff (!rstn)
    en_full |=> !gate_reg)
    else $error("gate enable high at stop count");

  a_mono_open: assert property (
    @(posedge clk) disable iff (!rstn)
    (mono && !first_state && !en_full) |=> gate_reg)
    else $error("later mono state did not open at once");

endmodule : lis_pwm_unit

// ==== hdl/lis_sequencer.sv ====
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module lis_sequencer
  import lis_pkg::*;
(
  input  wire logic                        REF_CLK,
  input  wire logic                        RSTN,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [lis_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic                        LED_LINE_START,
  input  wire logic                        TRANSFER_GATE_PULSE,
  output logic                             LED_RED,
  output logic                             LED_GREEN,
  output logic                             LED_BLUE,
  output logic                             LED_SHUNT,
  output logic [1:0]                       INDEX_A,
  output logic                             PWM_GATE_ENABLE,
  output logic                             PWM_LEVEL
);

  // ==========================================================
  // Functions
  function automatic logic [1:0] map_sel(input logic [7:0] map,
                                         input logic [1:0] idx);
    map_sel = map[{idx, 1'b0} +: 2];
  endfunction : map_sel

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  // ==========================================================
  // State
  lis_mode_e        mode_reg;
  logic [1:0]       seq_last_state_reg;
  logic [7:0]       map_reg;
  logic [DIV_W-1:0] pwm_clock_divider_reg;
  logic [PER_W-1:0] pwm_period_count_reg;
  logic [PER_W-1:0] pwm_on_count_reg;
  logic [EN_W-1:0]  enable_cycle_first_reg;
  logic [EN_W-1:0]  enable_cycle_last_reg;
  logic [1:0]       index_a_reg;
  logic [1:0]       index_a_next;
  logic             tg_d_reg;
  logic [2:0]       led_reg;
  logic [2:0]       led_next;
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic             pwm_gate_enable;
  logic             pwm_level;
  logic             period_done;

  // ==========================================================
  // Bus decode
  wire wr_en    = PSEL && PENABLE && PWRITE;
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  wire mapped   = hit(PADDR, ADDR_CTRL) || hit(PADDR, ADDR_MAP)
                || hit(PADDR, ADDR_PWM_CFG) || hit(PADDR, ADDR_PWM_ON)
                || hit(PADDR, ADDR_EN_CFG) || hit(PADDR, ADDR_STATUS);
  wire wr_ctrl  = wr_en && hit(PADDR, ADDR_CTRL);
  wire wr_map   = wr_en && hit(PADDR, ADDR_MAP);
  wire wr_cfg   = wr_en && hit(PADDR, ADDR_PWM_CFG);
  wire wr_on    = wr_en && hit(PADDR, ADDR_PWM_ON);
  wire wr_encfg = wr_en && hit(PADDR, ADDR_EN_CFG);

  // Zero wait states: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = prdata_reg;

  // ==========================================================
  // Sequencer decode
  wire mono     = (mode_reg == LIS_MONO);
  // restart is a plain level, checked every clock
  wire restart  = LED_LINE_START && TRANSFER_GATE_PULSE;
  // long gate pulses give one step
  wire tg_rise  = TRANSFER_GATE_PULSE && !tg_d_reg;
  // hold once index reaches last setting
  // Lowering the setting below the index must not let the index wrap
  wire at_last  = (index_a_reg >= seq_last_state_reg);
  wire adv_col  = !mono && tg_rise && !LED_LINE_START;
  // mono step at end of enable period
  wire adv_mono = mono && period_done;
  wire advance  = (adv_col || adv_mono) && !at_last;
  wire [1:0] sel = map_sel(map_reg, index_a_reg);
  wire drive    = !at_last && pwm_gate_enable && pwm_level;

  assign index_a_next = restart ? INDEX_RST
                      : advance ? index_a_reg + 2'h1 : index_a_reg;

  // last state steers current to shunt
  assign led_next = !drive ? 3'h0
                  : (sel == LED_SEL_RED)   ? 3'h1
                  : (sel == LED_SEL_GREEN) ? 3'h2
                  : (sel == LED_SEL_BLUE)  ? 3'h4 : 3'h0;

  always_comb begin
    prdata_next = 32'h0000_0000;
    case (PADDR)
      ADDR_CTRL: begin
        prdata_next[CTRL_MONO_POS] = mono;
        prdata_next[CTRL_LAST_LSB +: 2] = seq_last_state_reg;
      end
      ADDR_MAP:     prdata_next[7:0] = map_reg;
      ADDR_PWM_CFG: begin
        prdata_next[PER_W-1:0] = pwm_period_count_reg;
        prdata_next[CFG_DIV_LSB +: DIV_W] = pwm_clock_divider_reg;
      end
      ADDR_PWM_ON:  prdata_next[PER_W-1:0] = pwm_on_count_reg;
      ADDR_EN_CFG: begin
        prdata_next[EN_W-1:0] = enable_cycle_first_reg;
        prdata_next[EN_LAST_LSB +: EN_W] = enable_cycle_last_reg;
      end
      ADDR_STATUS:  prdata_next[4:0] = {pwm_level, pwm_gate_enable,
                                        at_last, index_a_reg};
      default:      prdata_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg           <= LIS_COLOUR;
      seq_last_state_reg <= LAST_RST;
      map_reg            <= MAP_RST;
    end else begin
      if (wr_ctrl) begin
        mode_reg           <= lis_mode_e'(PWDATA[CTRL_MONO_POS]);
        seq_last_state_reg <= PWDATA[CTRL_LAST_LSB +: 2];
      end
      if (wr_map) begin
        map_reg <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm_clock_divider_reg  <= DIV_RST;
      pwm_period_count_reg   <= PER_RST;
      pwm_on_count_reg       <= ON_RST;
      enable_cycle_first_reg <= EN_FIRST_RST;
      enable_cycle_last_reg  <= EN_LAST_RST;
    end else begin
      if (wr_cfg) begin
        pwm_period_count_reg  <= PWDATA[PER_W-1:0];
        pwm_clock_divider_reg <= PWDATA[CFG_DIV_LSB +: DIV_W];
      end
      if (wr_on) begin
        pwm_on_count_reg <= PWDATA[PER_W-1:0];
      end
      if (wr_encfg) begin
        enable_cycle_first_reg <= PWDATA[EN_W-1:0];
        enable_cycle_last_reg  <= PWDATA[EN_LAST_LSB +: EN_W];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      index_a_reg <= INDEX_RST;
      tg_d_reg    <= 1'b0;
      led_reg     <= 3'h0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      index_a_reg <= index_a_next;
      tg_d_reg    <= TRANSFER_GATE_PULSE;
      led_reg     <= led_next;
      if (rd_setup) begin
        prdata_reg <= prdata_next;
      end
    end
  end

  assign LED_RED         = led_reg[0];
  assign LED_GREEN       = led_reg[1];
  assign LED_BLUE        = led_reg[2];
  assign LED_SHUNT       = (led_reg == 3'h0);
  assign INDEX_A         = index_a_reg;
  assign PWM_GATE_ENABLE = pwm_gate_enable;
  assign PWM_LEVEL       = pwm_level;

  // ==========================================================
  // PWM engine; its enable count restarts with every state
  lis_pwm_unit u_pwm (
    .clk         (REF_CLK),
    .rstn        (RSTN),
    .restart     (restart),
    .state_step  (advance),
    .mono        (mono),
    .first_state (index_a_reg == 2'h0),
    .divider     (pwm_clock_divider_reg),
    .period      (pwm_period_count_reg),
    .on_count    (pwm_on_count_reg),
    .en_first    (enable_cycle_first_reg),
    .en_last     (enable_cycle_last_reg),
    .gate_en     (pwm_gate_enable),
    .level       (pwm_level),
    .period_done (period_done)
  );

  // ==========================================================
  // Checks
  a_restart_zero: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    restart |=> (index_a_reg == 2'h0))
    else $error("restart did not return index to zero");

  a_hold_last: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (at_last && !restart) |=> $stable(index_a_reg))
    else $error("index left last state without restart");

  a_colour_step: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (adv_col && !at_last && !restart)
      |=> (index_a_reg == $past(index_a_reg) + 2'h1))
    else $error("colour gate pulse did not step index");

  a_single_edge: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (!mono && !tg_rise && !restart) |=> $stable(index_a_reg))
    else $error("index moved without a gate edge");

  a_mono_step: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (adv_mono && !at_last && !restart)
      |=> (index_a_reg == $past(index_a_reg) + 2'h1))
    else $error("mono state did not step at period end");

  a_last_dark: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    at_last |=> (led_reg == 3'h0) && LED_SHUNT)
    else $error("LED driven at last state");

  a_one_led: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (drive && sel == LED_SEL_GREEN) |=> (led_reg == 3'h2))
    else $error("mapped LED not selected");

  a_index_limit: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (advance && !restart) |-> (index_a_reg < seq_last_state_reg))
    else $error("index stepped past last setting");

endmodule : lis_sequencer

// ==== inc/lis_pkg.sv ====
package lis_pkg;

  // ==========================================================
  // Widths
  localparam int DIV_W  = 4;
  localparam int PER_W  = 12;
  localparam int EN_W   = 8;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MAP     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PWM_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PWM_ON  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_EN_CFG  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_MONO_POS = 0;
  localparam int CTRL_LAST_LSB = 4;
  localparam int CFG_DIV_LSB   = 16;
  localparam int EN_LAST_LSB   = 8;

  // ==========================================================
  // Illumination choice codes
  localparam logic [1:0] LED_SEL_RED   = 2'h0;
  localparam logic [1:0] LED_SEL_GREEN = 2'h1;
  localparam logic [1:0] LED_SEL_BLUE  = 2'h2;
  localparam logic [1:0] LED_SEL_OFF   = 2'h3;

  // ==========================================================
  // Values after reset
  localparam logic [1:0]       LAST_RST     = 2'h3;
  localparam logic [7:0]       MAP_RST      = 8'hE4;
  localparam logic [DIV_W-1:0] DIV_RST      = 4'h0;
  localparam logic [PER_W-1:0] PER_RST      = 12'h0FF;
  localparam logic [PER_W-1:0] ON_RST       = 12'h080;
  localparam logic [EN_W-1:0]  EN_FIRST_RST = 8'h00;
  localparam logic [EN_W-1:0]  EN_LAST_RST  = 8'h10;
  localparam logic [1:0]       INDEX_RST    = 2'h0;

  typedef enum logic {LIS_COLOUR, LIS_MONO} lis_mode_e;

endpackage : lis_pkg

// ==== tb/led_illumination_sequencer_test.sv ====
`timescale 1ns/1ns
module led_illumination_sequencer_test;
  import lis_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, err;
  logic              led_r, led_g, led_b, shunt, gate_en, level;
  logic [1:0]        index;
  logic              req = 1'b0;
  logic              restart = 1'b0;
  logic              line_start, tg, busy;
  logic [3:0]        len = 4'h1;
  logic [7:0]        maps [2] = '{8'hE4, 8'h0B};
  logic [1:0]        code;
  int                fail_count = 0;
  int                total_checks = 0;
  int                hi, per;

  always #2 ref_clk = ~ref_clk;

  lis_sequencer dut (
    .REF_CLK(ref_clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LED_LINE_START(line_start),
    .TRANSFER_GATE_PULSE(tg), .LED_RED(led_r), .LED_GREEN(led_g),
    .LED_BLUE(led_b), .LED_SHUNT(shunt), .INDEX_A(index),
    .PWM_GATE_ENABLE(gate_en), .PWM_LEVEL(level)
  );

  lis_line_ctrl ctrl (
    .clk(ref_clk), .rstn(rstn), .req(req), .restart(restart), .len(len),
    .line_start(line_start), .tg(tg), .busy(busy)
  );

  // ==========================================================
  // Reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic give_up(input string what);
    fail_count++;
    $display("ERROR %0t timeout in %s", $time, what);
    close_out();
  endtask : give_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // ==========================================================
  // Bus and line drivers
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up("apb");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic rs, input logic [3:0] ln);
    int n;
    n = 0;
    @(posedge ref_clk);
    req     <= 1'b1;
    restart <= rs;
    len     <= ln;
    @(posedge ref_clk);
    req <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (busy !== 1'b0) give_up("pulse");
    repeat (2) @(posedge ref_clk);
  endtask : pulse

  function automatic logic [2:0] led_of(input logic [1:0] c);
    return (c == 2'h0) ? 3'b100 : (c == 2'h1) ? 3'b010 :
           (c == 2'h2) ? 3'b001 : 3'b000;
  endfunction : led_of

  // Sel 0 watches the index, sel 1 the three LED switches
  task automatic expect_within(input int sel, input logic [2:0] exp,
                               input int max);
    logic [2:0] v;
    for (int i = 0; i <= max; i++) begin
      @(negedge ref_clk);
      v = sel ? {led_r, led_g, led_b} : {1'b0, index};
      if (v === exp) break;
    end
    check({29'h0, v}, {29'h0, exp}, sel ? "leds" : "index");
  endtask : expect_within

  // High time and period, in clocks, of level (sel 0) or gate (sel 1)
  task automatic measure(input int sel, output int h, output int p);
    h = 0;
    p = 0;
    for (int i = 0; i < 100 && (sel ? gate_en : level) !== 1'b0; i++)
      @(negedge ref_clk);
    for (int i = 0; i < 100 && (sel ? gate_en : level) !== 1'b1; i++)
      @(negedge ref_clk);
    while ((sel ? gate_en : level) === 1'b1 && p < 100) begin
      @(negedge ref_clk);
      h++;
      p++;
    end
    while ((sel ? gate_en : level) === 1'b0 && p < 100) begin
      @(negedge ref_clk);
      p++;
    end
  endtask : measure

  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0030, "ctrl reset");
    check({31'h0, err}, 32'h0000_0000, "ctrl err");
    apb(1'b0, ADDR_MAP, 32'h0000_0000);
    check(rd, 32'h0000_00E4, "map reset");
    apb(1'b0, ADDR_PWM_CFG, 32'h0000_0000);
    check(rd, 32'h0000_00FF, "pwm cfg reset");
    apb(1'b0, ADDR_PWM_ON, 32'h0000_0000);
    check(rd, 32'h0000_0080, "pwm on reset");
    apb(1'b0, ADDR_EN_CFG, 32'h0000_0000);
    check(rd, 32'h0000_1000, "en cfg reset");
    apb(1'b1, ADDR_STATUS, 32'h0000_001F);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check(rd & 32'h0000_0007, 32'h0000_0000, "status ro");
    apb(1'b0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped data");
    check({31'h0, err}, 32'h0000_0001, "unmapped err");
    $display("test registers done");

    apb(1'b1, ADDR_PWM_CFG, 32'h0000_0003);
    apb(1'b1, ADDR_PWM_ON, 32'h0000_0FFF);
    apb(1'b1, ADDR_EN_CFG, 32'h0000_FF00);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ADDR_MAP, {24'h0, maps[m]});
      pulse(1'b1, 4'h3);
      expect_within(0, 3'h0, 0);
      for (int s = 0; s < 4; s++) begin
        code = maps[m][2*s +: 2];
        expect_within(1, (s == 3) ? 3'h0 : led_of(code), 30);
        check({31'h0, shunt}, {31'h0, ~|{led_r, led_g, led_b}}, "shunt");
        pulse(1'b0, 4'h5);
        expect_within(0, (s == 3) ? 3'h3 : 3'(s + 1), 0);
      end
    end
    $display("test colour run done");

    apb(1'b1, ADDR_CTRL, 32'h0000_0010);
    pulse(1'b0, 4'h2);
    expect_within(0, 3'h3, 0);
    pulse(1'b1, 4'h1);
    pulse(1'b0, 4'h2);
    expect_within(0, 3'h1, 0);
    pulse(1'b0, 4'h2);
    expect_within(0, 3'h1, 0);
    expect_within(1, 3'h0, 0);
    pulse(1'b1, 4'h2);
    expect_within(0, 3'h0, 0);
    $display("test short run done");

    apb(1'b1, ADDR_CTRL, 32'h0000_0030);
    apb(1'b1, ADDR_PWM_CFG, 32'h0001_0003);
    apb(1'b1, ADDR_PWM_ON, 32'h0000_0002);
    pulse(1'b1, 4'h1);
    measure(0, hi, per);
    check(hi, 32'd4, "level high");
    check(per, 32'd8, "level period");
    apb(1'b1, ADDR_PWM_CFG, 32'h0000_0003);
    apb(1'b1, ADDR_EN_CFG, 32'h0000_0402);
    pulse(1'b1, 4'h1);
    measure(1, hi, per);
    check(hi, 32'd8, "gate window");
    $display("test pwm done");

    apb(1'b1, ADDR_CTRL, 32'h0000_0031);
    pulse(1'b1, 4'h1);
    @(negedge ref_clk);
    check({31'h0, gate_en}, 32'h0000_0000, "mono first closed");
    expect_within(0, 3'h1, 60);
    @(negedge ref_clk);
    check({31'h0, gate_en}, 32'h0000_0001, "mono later open");
    expect_within(0, 3'h3, 200);
    pulse(1'b0, 4'h2);
    expect_within(0, 3'h3, 0);
    apb(1'b1, ADDR_EN_CFG, 32'h0000_0000);
    pulse(1'b1, 4'h1);
    repeat (60) @(posedge ref_clk);
    expect_within(0, 3'h0, 0);
    $display("test mono done");
    close_out();
  end
endmodule : led_illumination_sequencer_test

// ==== tb/lis_line_ctrl.sv ====
`timescale 1ns/1ns
module lis_line_ctrl (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       req,
  input  wire logic       restart,
  input  wire logic [3:0] len,
  output logic            line_start,
  output logic            tg,
  output logic            busy
);
  logic [3:0] left_reg;

  // ==========================================================
  // Line pulse generator
  // A long len models a slow controller holding the gate high
  // restart raises both lines together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_start <= 1'b0;
      tg         <= 1'b0;
      left_reg   <= 4'h0;
    end else if (req) begin
      line_start <= restart;
      tg         <= 1'b1;
      left_reg   <= len;
    end else if (left_reg > 4'h1) begin
      left_reg <= left_reg - 4'h1;
    end else begin
      line_start <= 1'b0;
      tg         <= 1'b0;
      left_reg   <= 4'h0;
    end
  end

  assign busy = tg;
endmodule : lis_line_ctrl
